// ===== design/trgcw_pkg.sv
package trgcw_pkg;

  // base clock
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned CLK_NS          = 40;
  // one character space: 1 / (density * velocity)
  localparam int unsigned DENSITY_BPI     = 800;
  localparam int unsigned VELOCITY_IPS    = 25;
  localparam int unsigned CHAR_SPACE_NS   = 1000000000 / (DENSITY_BPI * VELOCITY_IPS);
  localparam int unsigned CHAR_CYC        = CHAR_SPACE_NS / CLK_NS;
  // write pulse delay behind each strobe, least time rounds up
  localparam int unsigned WR_DELAY_US     = 15;
  localparam int unsigned WR_DELAY_CYC    = (WR_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
  // gap placement in character spaces
  localparam int unsigned CHECK_SPACES    = 4;
  // gap lengths in thousandths of an inch
  localparam int unsigned GAP7_MIL        = 750;
  localparam int unsigned GAP9_MIL        = 600;
  localparam int unsigned FILE_GAP_MIL    = 3800;
  // tape stop time, in milliseconds and in cycles
  localparam int unsigned STOP_MS         = 5;
  localparam int unsigned STOP_CYC        = STOP_MS * (CLK_HZ / 1000);
  // characters per inch -> cycles per mil
  localparam int unsigned CYC_PER_MIL     = (CHAR_CYC * DENSITY_BPI) / 1000;
  localparam int unsigned RUN7_CYC        = CYC_PER_MIL * GAP7_MIL / 2;
  localparam int unsigned RUN9_CYC        = CYC_PER_MIL * GAP9_MIL / 2;
  localparam int unsigned FILE_RUN_CYC    = CYC_PER_MIL * FILE_GAP_MIL;
  // check and mark characters, bit 8 is parity
  localparam logic [8:0]  FILE_MARK_7     = 9'h00F;
  localparam logic [8:0]  FILE_MARK_9     = 9'h0C8;
  localparam logic [8:0]  CRC_INV_MASK    = 9'h1EB;
  localparam int unsigned FIFO_DEPTH      = 32;

endpackage : trgcw_pkg

// ===== design/trgcw_fifo.sv
`timescale 1ns/1ps
module trgcw_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // honest flags from the occupancy count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage, no reset needed on data
  always_ff @(posedge sys_clk)
  begin
    if (clk_en && push)
      mem_q[wr_q] <= in_data;
  end

  // pointers and count
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : trgcw_fifo

// ===== design/trgcw_writer.sv
// Behaviour
// - fold each data bit into matching check register bit by xor, no carry
// - rotate check register one place between characters, bit seven wraps to parity
// - when rotation puts a one into parity, invert bits entering two to five
// - after last character, rotate once more with same rules
// - invert all check bits except two and four, then record as cyclic check
// - longitudinal check makes every track's count of ones even
// - seven-track record gap is 0.75 inch
// - seven-track longitudinal check four spaces after last data character
// - nine-track record gap is 0.6 inch
// - nine-track cyclic check at four spaces, longitudinal at eight
// - seven-track file gap: check, 3.8 inch run, mark, gap with its check
// - nine-track file gap: checks, run, mark on 3,6,7, longitudinal only
// - dropping forward inserts gap with checks, half while stopping
// - gap command under forward inserts gap without stopping
// - each accepted strobe makes a head write pulse 15 us later
// - forward falling edge sets data busy and starts command busy interval
// - forward during command busy is held until the interval ends
// - four spaces after forward ends (eight on nine-track), prime pulse clears buffer, writes check
// - after forward returns, fixed delay before data busy is released
// - nine-track: forward end opens four-space cyclic finish gate
`timescale 1ns/1ps
module trgcw_writer
  import trgcw_pkg::*;
#(
  parameter int unsigned STOP_CYCLES = STOP_CYC,
  parameter int unsigned RUN7_CYCLES = RUN7_CYC,
  parameter int unsigned RUN9_CYCLES = RUN9_CYC,
  parameter int unsigned FILE_CYCLES = FILE_RUN_CYC
) (
  // clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  // mode strap, high for nine tracks
  input  wire logic       nine_track,
  // controller commands and data
  input  wire logic       fwd_cmd,
  input  wire logic       gap_cmd,
  input  wire logic       file_gap_cmd,
  input  wire logic       wr_strobe,
  input  wire logic [8:0] wr_data,
  // status to controller
  output logic            data_busy,
  output logic            cmd_busy,
  output logic            motor_fwd,
  // head side
  output logic            head_wr_pulse,
  output logic [8:0]      head_char,
  output logic            longitudinal_prime_pulse,
  output logic            cyclic_finish_gate
);

  localparam int unsigned CW = 32;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_DATA  = 7'h02,
    ST_CRC   = 7'h04,
    ST_LRC   = 7'h08,
    ST_FRUN  = 7'h10,
    ST_MARK  = 7'h20,
    ST_RUN   = 7'h40
  } trgcw_state_t;

  // input synchronisers, two flops each
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [8:0] dat1_q;
  logic [8:0] dat2_q;
  logic       fwd_s;
  logic       gap_s;
  logic       fgap_s;
  logic       stb_s;
  logic       fwd_d1_q;
  logic       gap_d1_q;
  logic       stb_d1_q;

  assign stb_s  = sync2_q[0];
  assign fwd_s  = sync2_q[1];
  assign gap_s  = sync2_q[2];
  assign fgap_s = sync2_q[3];

  // pins pass two flops; edge history reads only the second stage
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q  <= 4'h0;
      sync2_q  <= 4'h0;
      dat1_q   <= 9'h000;
      dat2_q   <= 9'h000;
      fwd_d1_q <= 1'b0;
      gap_d1_q <= 1'b0;
      stb_d1_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_q  <= {file_gap_cmd, gap_cmd, fwd_cmd, wr_strobe};
      sync2_q  <= sync1_q;
      dat1_q   <= wr_data;
      dat2_q   <= dat1_q;
      fwd_d1_q <= fwd_s;
      gap_d1_q <= gap_s;
      stb_d1_q <= stb_s;
    end
  end

  logic stb_rise;
  logic fwd_fall;
  logic gap_rise;
  assign stb_rise = stb_s & ~stb_d1_q;
  assign fwd_fall = ~fwd_s & fwd_d1_q;
  assign gap_rise = gap_s & ~gap_d1_q & fwd_s;

  // strobes are only honoured while data busy is low (masked here, not left to the controller)
  logic       strobe_ok;
  assign strobe_ok = stb_rise & ~data_busy;

  // state and timers
  trgcw_state_t st_q;
  logic [CW-1:0] tmr_q;
  logic          stopping_q;
  logic          file_q;
  logic          mark_done_q;
  logic [CW-1:0] stop_q;
  logic [8:0]    crc_q;
  logic [8:0]    lrc_q;
  logic          end_rec;
  logic          tmr_done;

  assign end_rec  = (st_q == ST_DATA || st_q == ST_IDLE) && (fwd_fall || gap_rise);
  assign tmr_done = (tmr_q == '0);

  // four character spaces in cycles, scaled for all placements
  localparam logic [CW-1:0] CHECK_CYC = CW'(CHECK_SPACES * CHAR_CYC);

  // check register rotate: parity<-bit7, bit0<-parity, feedback on 2..5
  function automatic logic [8:0] trgcw_rotate(input logic [8:0] c);
    logic [8:0] r;
    r = {c[7:0], c[8]};
    if (c[7])
      r[5:2] = ~r[5:2];
    return r;
  endfunction : trgcw_rotate

  // rotate from the previous character, then add without carry
  logic [8:0] crc_fold;
  assign crc_fold = (st_q == ST_DATA ? trgcw_rotate(crc_q) : 9'h000) ^ dat2_q;

  // data feeds the fifo at strobe, drains at each data head write, not at check writes
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic       fifo_pop;

  trgcw_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .in_valid  (strobe_ok),
    .in_ready  (fifo_in_ready),
    .in_data   (dat2_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // one strobe delay counter; one pending write at a time
  logic [CW-1:0] dly_q;
  logic          dly_run_q;
  logic          extra_q;
  logic [8:0]    extra_char_q;
  logic          data_wr;
  assign data_wr  = dly_run_q && dly_q == '0 && fifo_out_valid;
  assign fifo_pop = data_wr;

  // fixed 15 us write delay; a full fifo drops strobe which stalls nothing
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dly_q     <= '0;
      dly_run_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (strobe_ok && fifo_in_ready)
      begin
        dly_q     <= CW'(WR_DELAY_CYC - 1);
        dly_run_q <= 1'b1;
      end
      else if (dly_run_q && dly_q != '0)
        dly_q <= dly_q - CW'(1);
      else
        dly_run_q <= 1'b0;
    end
  end

  // check accumulation per data character and at record end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crc_q <= 9'h000;
      lrc_q <= 9'h000;
    end
    else if (clk_en)
    begin
      if (strobe_ok && fifo_in_ready)
      begin
        // the last strobe lands with the record end, so it also takes the closing rotation
        crc_q <= end_rec ? trgcw_rotate(crc_fold) : crc_fold;
        lrc_q <= (st_q == ST_DATA ? lrc_q : 9'h000) ^ dat2_q;
      end
      else if (end_rec && nine_track)
        crc_q <= trgcw_rotate(crc_q);
      else if (st_q == ST_CRC && tmr_done)
        lrc_q <= lrc_q ^ (crc_q ^ CRC_INV_MASK);
      else if (st_q == ST_MARK && tmr_done)
        lrc_q <= nine_track ? FILE_MARK_9 : FILE_MARK_7;
    end
  end

  // gap sequencer
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q         <= ST_IDLE;
      tmr_q        <= '0;
      file_q       <= 1'b0;
      mark_done_q  <= 1'b0;
      extra_q      <= 1'b0;
      extra_char_q <= 9'h000;
    end
    else if (clk_en)
    begin
      extra_q <= 1'b0;
      case (st_q)
        ST_IDLE, ST_DATA:
        begin
          if (strobe_ok)
            st_q <= ST_DATA;
          if (end_rec)
          begin
            file_q      <= fgap_s;
            mark_done_q <= 1'b0;
            tmr_q       <= CHECK_CYC - CW'(1);
            st_q        <= nine_track ? ST_CRC : ST_LRC;
          end
        end
        ST_CRC:
        begin
          if (tmr_done)
          begin
            extra_q      <= 1'b1;
            extra_char_q <= crc_q ^ CRC_INV_MASK;
            tmr_q        <= CHECK_CYC - CW'(1);
            st_q         <= ST_LRC;
          end
          else
            tmr_q <= tmr_q - CW'(1);
        end
        ST_LRC:
        begin
          if (tmr_done)
          begin
            extra_q      <= 1'b1;
            extra_char_q <= lrc_q;
            if (file_q && !mark_done_q)
            begin
              tmr_q <= CW'(FILE_CYCLES);
              st_q  <= ST_FRUN;
            end
            else
            begin
              tmr_q <= CW'(nine_track ? RUN9_CYCLES : RUN7_CYCLES);
              st_q  <= ST_RUN;
            end
          end
          else
            tmr_q <= tmr_q - CW'(1);
        end
        ST_FRUN:
        begin
          if (tmr_done)
            st_q <= ST_MARK;
          else
            tmr_q <= tmr_q - CW'(1);
        end
        ST_MARK:
        begin
          // file mark, then its own longitudinal check, never a cyclic one
          extra_q      <= 1'b1;
          extra_char_q <= nine_track ? FILE_MARK_9 : FILE_MARK_7;
          mark_done_q  <= 1'b1;
          tmr_q        <= CW'(nine_track ? 2 * CHECK_CYC : CHECK_CYC) - CW'(1);
          st_q         <= ST_LRC;
        end
        ST_RUN:
        begin
          // run counts only while moving forward; held on a stop
          if (tmr_done)
            st_q <= ST_IDLE;
          else if (motor_fwd)
            tmr_q <= tmr_q - CW'(1);
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // command busy interval from forward falling edge until tape stopped
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stopping_q <= 1'b0;
      stop_q     <= '0;
    end
    else if (clk_en)
    begin
      if (fwd_fall)
      begin
        stopping_q <= 1'b1;
        stop_q     <= CW'(STOP_CYCLES);
      end
      else if (stopping_q && stop_q == '0)
        stopping_q <= 1'b0;
      else if (stopping_q)
        stop_q <= stop_q - CW'(1);
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_busy                <= 1'b0;
      cmd_busy                 <= 1'b0;
      motor_fwd                <= 1'b0;
      head_wr_pulse            <= 1'b0;
      head_char                <= 9'h000;
      longitudinal_prime_pulse <= 1'b0;
      cyclic_finish_gate       <= 1'b0;
    end
    else if (clk_en)
    begin
      data_busy <= (end_rec || (st_q != ST_IDLE && st_q != ST_DATA)) || (data_busy && st_q != ST_IDLE);
      cmd_busy  <= stopping_q | fwd_fall;
      // tape also keeps running through the file run
      motor_fwd <= (fwd_s && !stopping_q && !fwd_fall) || st_q == ST_FRUN;
      head_wr_pulse <= data_wr | extra_q;
      if (data_wr)
        head_char <= fifo_out_data;
      else if (extra_q)
        head_char <= extra_char_q;
      // two cycles ahead of the check write pulse so the buffer clear leads it
      longitudinal_prime_pulse <= st_q == ST_LRC && tmr_q == CW'(1);
      cyclic_finish_gate <= st_q == ST_CRC && !tmr_done;
    end
  end

endmodule : trgcw_writer

// ===== testbench/trgcw_monitor.sv
`timescale 1ns/1ps
module trgcw_monitor (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       clk_en,
  // controller side
  input wire logic       nine_track,
  input wire logic       fwd_cmd,
  input wire logic       gap_cmd,
  input wire logic       file_gap_cmd,
  input wire logic       wr_strobe,
  input wire logic [8:0] wr_data,
  // status and head side
  input wire logic       data_busy,
  input wire logic       cmd_busy,
  input wire logic       motor_fwd,
  input wire logic       head_wr_pulse,
  input wire logic [8:0] head_char,
  input wire logic       longitudinal_prime_pulse,
  input wire logic       cyclic_finish_gate
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // stopping and gapping raise the interlocks within the sync delay
  chk_busy_on_stop: assert property ($fell(fwd_cmd) |-> ##[2:5] data_busy)
    else $error("data busy late after forward drop");
  chk_stop_interval: assert property ($fell(fwd_cmd) |-> ##[2:6] cmd_busy)
    else $error("command busy late after forward drop");
  chk_busy_on_gap: assert property ($rose(gap_cmd) && fwd_cmd |-> ##[2:5] data_busy)
    else $error("data busy late after gap command");
  // motion restarts only once the stop interval is over
  chk_hold_motion: assert property ($rose(motor_fwd) |-> !cmd_busy)
    else $error("motor started inside stop interval");
  // accepted strobe gives one head pulse after the fixed delay
  chk_write_delay: assert property ($rose(wr_strobe) && !data_busy && !cmd_busy |-> ##[376:379] head_wr_pulse)
    else $error("head pulse not at strobe delay");
  chk_one_pulse: assert property (head_wr_pulse |=> !head_wr_pulse)
    else $error("head pulse longer than one cycle");
  chk_char_hold: assert property ($changed(head_char) |-> head_wr_pulse)
    else $error("head char moved without pulse");
  chk_prime_write: assert property (longitudinal_prime_pulse |-> ##[1:400] head_wr_pulse)
    else $error("no write after prime pulse");
  chk_gate_mode: assert property (cyclic_finish_gate |-> nine_track)
    else $error("cyclic gate in seven-track mode");
  chk_busy_release: assert property ($fell(data_busy) |-> motor_fwd && fwd_cmd)
    else $error("data busy released while stopped");
endmodule : trgcw_monitor

// ===== testbench/trgcw_ctrl_model.sv
`timescale 1ns/1ps
module trgcw_ctrl_model (
  // clock and status from the block
  input  wire logic       sys_clk,
  input  wire logic       data_busy,
  // commands and data to the block
  output logic            fwd_cmd,
  output logic            gap_cmd,
  output logic            file_gap_cmd,
  output logic            wr_strobe,
  output logic [8:0]      wr_data
);
  // idle levels at time zero
  initial
  begin
    fwd_cmd      = 1'b0;
    gap_cmd      = 1'b0;
    file_gap_cmd = 1'b0;
    wr_strobe    = 1'b0;
    wr_data      = 9'h1FF;
  end

  // raise forward and wait for data busy to clear, bounded
  task automatic go(output logic ok);
    int n;
    fwd_cmd      <= 1'b1;
    gap_cmd      <= 1'b0;
    file_gap_cmd <= 1'b0;
    n = 0;
    repeat (8) @(posedge sys_clk);
    while (data_busy !== 1'b0 && n < 60000)
    begin
      @(posedge sys_clk);
      n++;
    end
    ok = (data_busy === 1'b0);
  endtask : go

  // one character; kind 1 drops forward, 2 gives a gap, 3 a file gap
  task automatic put(input logic [8:0] ch, input int kind, input bit force_it);
    int n;
    n = 0;
    while (!force_it && data_busy !== 1'b0 && n < 60000)
    begin
      @(posedge sys_clk);
      n++;
    end
    wr_data <= ch;
    repeat (3) @(posedge sys_clk);
    wr_strobe <= 1'b1;
    if (kind == 1 || kind == 3)
      fwd_cmd <= 1'b0;
    if (kind == 2)
      gap_cmd <= 1'b1;
    if (kind == 3)
      file_gap_cmd <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr_strobe <= 1'b0;
    repeat (3) @(posedge sys_clk);
    wr_data <= ~ch; // released data no longer shows the character
    repeat (400) @(posedge sys_clk);
  endtask : put

  // drop forward with no data, raise it again after hold cycles
  task automatic bounce(input int hold);
    fwd_cmd <= 1'b0;
    repeat (hold) @(posedge sys_clk);
    fwd_cmd <= 1'b1;
  endtask : bounce
endmodule : trgcw_ctrl_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic            nine;
    logic [1:0]      kind;
    logic [2:0][8:0] d;
  } trgcw_row_t;

  logic       sys_clk;
  logic       rst_b;
  logic       nine_track;
  logic       fwd_cmd, gap_cmd, file_gap_cmd, wr_strobe;
  logic [8:0] wr_data;
  logic       data_busy, cmd_busy, motor_fwd, head_wr_pulse;
  logic [8:0] head_char;
  logic       longitudinal_prime_pulse, cyclic_finish_gate;
  logic [8:0] got [$];
  int         err_total;
  int         n_checks;
  logic       clk_en;
  logic       go_ok;

  // record end kinds: 1 forward drop, 2 gap on the fly, 3 file gap
  trgcw_row_t rows [6] = '{
    '{1'b0, 2'd1, {9'h041, 9'h123, 9'h17F}},
    '{1'b0, 2'd2, {9'h100, 9'h02A, 9'h055}},
    '{1'b0, 2'd3, {9'h07F, 9'h000, 9'h112}},
    '{1'b1, 2'd1, {9'h1FF, 9'h080, 9'h0C3}},
    '{1'b1, 2'd2, {9'h1A5, 9'h05A, 9'h0F0}},
    '{1'b1, 2'd3, {9'h081, 9'h142, 9'h024}}
  };

  // counts shortened so a record end stays short
  trgcw_writer #(.STOP_CYCLES(50), .RUN7_CYCLES(100), .RUN9_CYCLES(100), .FILE_CYCLES(300)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .nine_track(nine_track),
    .fwd_cmd(fwd_cmd), .gap_cmd(gap_cmd), .file_gap_cmd(file_gap_cmd),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .data_busy(data_busy), .cmd_busy(cmd_busy),
    .motor_fwd(motor_fwd), .head_wr_pulse(head_wr_pulse), .head_char(head_char),
    .longitudinal_prime_pulse(longitudinal_prime_pulse), .cyclic_finish_gate(cyclic_finish_gate));

  trgcw_ctrl_model ctrl (
    .sys_clk(sys_clk), .data_busy(data_busy), .fwd_cmd(fwd_cmd), .gap_cmd(gap_cmd),
    .file_gap_cmd(file_gap_cmd), .wr_strobe(wr_strobe), .wr_data(wr_data));

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // capture every character the head writes
  always @(posedge sys_clk)
    if (head_wr_pulse === 1'b1)
      got.push_back(head_char);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      err_total++;
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // one record; the strap only changes under reset, extra adds a strobe while busy
  task automatic run_row(input trgcw_row_t r, input bit extra);
    logic [8:0] exp [$];
    logic [8:0] crc, lrc, mk;
    logic       ok;
    if (r.nine !== nine_track)
    begin
      @(posedge sys_clk);
      rst_b      <= 1'b0;
      nine_track <= r.nine;
      @(posedge sys_clk);
      #1;
      check("outputs in reset", {data_busy, cmd_busy, motor_fwd, head_wr_pulse, head_char}, 0);
      @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
    end
    ctrl.go(ok);
    check("start", ok, 1);
    got.delete();
    crc = 9'h000;
    lrc = 9'h000;
    for (int j = 0; j < 3; j++)
    begin
      exp.push_back(r.d[j]);
      crc ^= r.d[j];
      crc = {crc[7], crc[6:0], crc[8]} ^ (crc[7] ? 9'h03C : 9'h000);
      lrc ^= r.d[j];
      ctrl.put(r.d[j], (j == 2) ? int'(r.kind) : 0, 1'b0);
    end
    if (extra)
      ctrl.put(9'h0AA, 0, 1'b1); // refused, data busy is up
    crc ^= trgcw_pkg::CRC_INV_MASK;
    if (r.nine)
    begin
      exp.push_back(crc);
      lrc ^= crc;
    end
    exp.push_back(lrc);
    if (r.kind == 2'd3)
    begin
      mk = r.nine ? trgcw_pkg::FILE_MARK_9 : trgcw_pkg::FILE_MARK_7;
      exp.push_back(mk);
      exp.push_back(mk);
    end
    ctrl.go(ok);
    check("resume", ok, 1);
    repeat (400) @(posedge sys_clk);
    check("char count", got.size(), exp.size());
    foreach (exp[k])
      check("head char", (k < got.size()) ? got[k] : ~exp[k], exp[k]);
  endtask : run_row

  // main sequence, then a strap change with a refused strobe
  initial
  begin
    err_total  = 0;
    n_checks   = 0;
    rst_b      = 1'b0;
    nine_track = 1'b0;
    clk_en     = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (rows[i])
      run_row(rows[i], 1'b0);
    run_row(rows[0], 1'b1);
    // forward back inside the stop interval, then a freeze stretches the interval
    ctrl.bounce(10);
    repeat (20) @(posedge sys_clk);
    check("held in stop", {motor_fwd, cmd_busy}, 2'b01);
    clk_en <= 1'b0;
    repeat (100) @(posedge sys_clk);
    check("frozen stop", {motor_fwd, cmd_busy}, 2'b01);
    clk_en <= 1'b1;
    repeat (70) @(posedge sys_clk);
    check("motion after stop", {motor_fwd, cmd_busy}, 2'b10);
    ctrl.go(go_ok);
    check("gap after bounce", go_ok, 1);
    close_out();
  end

  // the whole run, near 80000 cycles, stays below this span
  initial
  begin
    repeat (95000) @(posedge sys_clk);
    err_total++;
    close_out();
  end
endmodule : tb_top

bind trgcw_writer trgcw_monitor mon (
  .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .nine_track(nine_track),
  .fwd_cmd(fwd_cmd), .gap_cmd(gap_cmd), .file_gap_cmd(file_gap_cmd),
  .wr_strobe(wr_strobe), .wr_data(wr_data), .data_busy(data_busy), .cmd_busy(cmd_busy),
  .motor_fwd(motor_fwd), .head_wr_pulse(head_wr_pulse), .head_char(head_char),
  .longitudinal_prime_pulse(longitudinal_prime_pulse), .cyclic_finish_gate(cyclic_finish_gate));
